// ---- inc/rsr_pkg.sv ----
// Purpose: Constants and types for the reset and stop-mode-recovery controller
// Assumes: 10 MHz pclk; oscillator cycles arrive as a one-cycle enable
// Notes: Register offsets are byte addresses on APB
//
// Operation
// [R01] Start system reset on power-on, low supply, enabled watchdog, enabled pin.
// [R02] Start system reset when debugger control bit 0 is one.
// [R03] In stop mode, recover on watchdog time-out or enabled pin transition.
// [R04] Assert low-supply reset whenever supply monitor reports low voltage.
// [R05] Hold reset 66 oscillator cycles after oscillator start.
// [R06] Hold 5000 oscillator cycles when crystal option is enabled.
// [R07] Wait 4 us oscillator start-up before counting hold cycles.
// [R08] Power and low-supply resets time only after supply exceeds threshold.
// [R09] Stay in reset while pin low; leave on first edge after release.
// [R10] External agent holds reset pin low at least four clock periods.
// [R11] Pin-caused reset sets external reset cause flag.
// [R12] Reset pin is open-drain low indicator during reset or when enabled.
// [R13] Internal reset pulls pin low until hold period elapses.
// [R14] At reset start all port pins become inputs, pull-ups off.
// [R15] During reset idle processor and peripherals, oscillators keep running.
// [R16] System reset loads control register defaults; others stay undefined.
// [R17] On exit, fetch vector from bytes 0002H and 0003H.
// [R18] System reset always selects internal oscillator as clock.
// [R19] Stop recovery resets processor, touching only watchdog and oscillator control.
// [R20] Debugger reset resets everything except the debugger.
// [R21] Debugger reset request bit clears itself during the reset.
// [R22] Debugger reset sets power-on cause flag.
// [R23] After stop recovery, enable internal oscillator and select it; osc_select_internal clears on return to RSR_RUN.
// [R24] Synchronise pin; restart hold counter on new source during hold.
package rsr_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] RSR_OFS_DBG_CTL = 12'h000;
  localparam logic [11:0] RSR_OFS_STATUS = 12'h004;
  localparam logic [11:0] RSR_OFS_CONFIG = 12'h008;
  localparam logic [11:0] RSR_OFS_CLEAR = 12'h00c;
  localparam int RSR_BIT_DBG_RST = 0;
  localparam int RSR_BIT_POR = 7;
  localparam int RSR_BIT_STOP = 6;
  localparam int RSR_BIT_WDT = 5;
  localparam int RSR_BIT_EXT = 4;
  localparam logic [7:0] RSR_STATUS_RESET = 8'h80;
  localparam logic [3:0] RSR_CONFIG_RESET = 4'h0;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int RSR_CLK_HZ = 10_000_000;
  localparam int RSR_START_NS = 4000;
  localparam int RSR_START_CYC = (RSR_START_NS * (RSR_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [12:0] RSR_HOLD_SHORT = 13'h0042;
  localparam logic [12:0] RSR_HOLD_XTAL = 13'h1388;
  localparam logic [15:0] RSR_VECTOR_ADDR = 16'h0002;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [3:0] {
    RSR_RUN = 4'b0001,
    RSR_START = 4'b0010,
    RSR_HOLD = 4'b0100,
    RSR_PIN_WAIT = 4'b1000
  } rsr_state_t;
  typedef struct packed {
    logic xtal_en;
    logic wdt_reset_opt;
    logic pin_reset_en;
    logic pin_ind_en;
  } rsr_config_t;
endpackage

// ---- sim/rsr_checker.sv ----
// Purpose: Port-level checks for rsr_ctrl
// Assumes: Bound to rsr_ctrl, single pclk domain
// Notes: Sees design ports only
`timescale 1ns/100ps
`default_nettype none
module rsr_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic low_supply_detect,
  input wire logic stop_mode,
  input wire logic recovery_pin_edge,
  input wire logic reset_pin_in,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic sys_reset,
  input wire logic cpu_reset,
  input wire logic ports_to_input,
  input wire logic regs_load_defaults,
  input wire logic osc_select_internal,
  input wire logic [15:0] vector_fetch_addr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_vec; vector_fetch_addr == 16'h0002; endproperty
  a_vec: assert property (p_vec) else $error("vector address wrong");
  property p_odr; reset_pin_out == 1'b0; endproperty
  a_odr: assert property (p_odr) else $error("pin driven high");
  property p_low; low_supply_detect |-> ##[0:3] cpu_reset; endproperty
  a_low: assert property (p_low) else $error("no low supply reset");
  property p_prt; $rose(sys_reset) |-> ##[0:2] ports_to_input; endproperty
  a_prt: assert property (p_prt) else $error("ports not input");
  property p_osc; $rose(cpu_reset) |-> ##[0:2] osc_select_internal; endproperty
  a_osc: assert property (p_osc) else $error("clock not internal");
  property p_pin; cpu_reset && !reset_pin_oe && !reset_pin_in |=> cpu_reset; endproperty
  a_pin: assert property (p_pin) else $error("left reset with pin low");
  property p_stp; stop_mode && recovery_pin_edge |-> ##[0:3] cpu_reset; endproperty
  a_stp: assert property (p_stp) else $error("no stop recovery");
  property p_smr; stop_mode && cpu_reset && !sys_reset |-> !regs_load_defaults; endproperty
  a_smr: assert property (p_smr) else $error("defaults on stop recovery");
  property p_def; $rose(sys_reset) |-> ##[0:2] regs_load_defaults; endproperty
  a_def: assert property (p_def) else $error("no default load");
endmodule
`default_nettype wire

// ---- sim/rsr_ctrl_tb_top.sv ----
// Purpose: Self-checking bench for rsr_ctrl
// Assumes: osc_tick on every second pclk
// Notes: Reset pin closed by rsr_pin_model
`timescale 1ns/100ps
`default_nettype none
module rsr_ctrl_tb_top;
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic e;} rsr_row_t;
  localparam int SH = rsr_pkg::RSR_START_CYC + 2 * int'(rsr_pkg::RSR_HOLD_SHORT);
  localparam int LH = rsr_pkg::RSR_START_CYC + 2 * int'(rsr_pkg::RSR_HOLD_XTAL);
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
  logic osc_tick = 1'b0, supply_above_por = 1'b1, low_supply_detect = 1'b0, pready, e;
  logic watchdog_timeout = 1'b0, stop_mode = 1'b0, recovery_pin_edge = 1'b0, pslverr;
  logic reset_pin_in, reset_pin_out, reset_pin_oe, sys_reset, cpu_reset, ports_to_input;
  logic regs_load_defaults, osc_select_internal;
  logic [11:0] paddr = 12'h000;
  logic [15:0] vector_fetch_addr, low_len = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  int err_count = 0, num_checks = 0;
  rsr_row_t rows [4] = '{'{12'h004, 32'h0000_0080, 1'b0}, '{12'h008, 32'h0000_0000, 1'b0},
    '{12'h000, 32'h0000_0000, 1'b0}, '{12'h010, 32'h0000_0000, 1'b1}};
  always #50 pclk = !pclk;
  always @(posedge pclk) osc_tick <= !osc_tick;
  rsr_ctrl rsr_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .osc_tick, .supply_above_por, .low_supply_detect, .watchdog_timeout,
    .stop_mode, .recovery_pin_edge, .reset_pin_in, .reset_pin_out, .reset_pin_oe, .sys_reset,
    .cpu_reset, .ports_to_input, .regs_load_defaults, .osc_select_internal, .vector_fetch_addr);
  rsr_pin_model rsr_pin_model_i (.pclk, .reset_pin_out, .reset_pin_oe, .low_len, .go,
    .pin_level(reset_pin_in));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    check(nm, q, x);
  endtask
  task automatic setup(input logic [31:0] cfg);
    apb(1'b1, 12'h00c, 32'h0000_00f0);
    apb(1'b1, 12'h008, cfg);
  endtask
  task automatic hold_len(input int lo, input int hi, input logic s, input string nm);
    int n;
    n = 5;
    repeat (5) @(posedge pclk);
    check("system reset", 32'(sys_reset), 32'(s));
    check("ports input", 32'(ports_to_input), 32'(s));
    check("internal clock", 32'(osc_select_internal), 32'h0000_0001);
    if (s) check("pin low", 32'(reset_pin_in), 32'h0000_0000);
    while (cpu_reset === 1'b1 && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    check(nm, 32'(n >= lo - 2 && n <= hi), 32'h0000_0001);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    hold_len(SH, SH + 16, 1'b1, "power hold");
    foreach (rows[i]) begin
      apb(1'b0, rows[i].a, 32'h0000_0000);
      check("read error", 32'(e), 32'(rows[i].e));
      if (!rows[i].e) check("reset value", q, rows[i].d);
    end
    setup(32'h0000_0000);
    apb(1'b1, 12'h000, 32'h0000_0001);
    hold_len(SH, SH + 16, 1'b1, "debug hold");
    rd(12'h000, 32'h0000_0000, "debug bit");
    rd(12'h004, 32'h0000_0080, "debug cause");
    setup(32'h0000_0002);
    low_len <= 16'h0004;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    hold_len(SH, SH + 20, 1'b1, "pin hold");
    rd(12'h004, 32'h0000_0010, "pin cause");
    setup(32'h0000_0002);
    low_len <= 16'h0190;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    hold_len(400, 416, 1'b1, "pin held");
    setup(32'h0000_000c);
    watchdog_timeout <= 1'b1;
    @(posedge pclk);
    watchdog_timeout <= 1'b0;
    hold_len(LH, LH + 16, 1'b1, "crystal hold");
    rd(12'h004, 32'h0000_0020, "watchdog cause");
    setup(32'h0000_0004);
    stop_mode <= 1'b1;
    recovery_pin_edge <= 1'b1;
    @(posedge pclk);
    recovery_pin_edge <= 1'b0;
    hold_len(SH, SH + 16, 1'b0, "stop hold");
    stop_mode <= 1'b0;
    rd(12'h008, 32'h0000_0004, "config kept");
    rd(12'h004, 32'h0000_0040, "stop cause");
    low_supply_detect <= 1'b1;
    supply_above_por <= 1'b0;
    repeat (300) @(posedge pclk);
    check("low supply", 32'(cpu_reset), 32'h0000_0001);
    low_supply_detect <= 1'b0;
    supply_above_por <= 1'b1;
    hold_len(SH, SH + 16, 1'b1, "supply hold");
    close_out();
  end
  initial begin
    #4_000_000;
    err_count++;
    close_out();
  end
endmodule
bind rsr_ctrl rsr_checker rsr_checker_i (.pclk, .presetn, .low_supply_detect, .stop_mode,
  .recovery_pin_edge, .reset_pin_in, .reset_pin_out, .reset_pin_oe, .sys_reset, .cpu_reset,
  .ports_to_input,
  .regs_load_defaults, .osc_select_internal, .vector_fetch_addr);
`default_nettype wire

// ---- sim/rsr_pin_model.sv ----
// Purpose: Board side of the reset pin
// Assumes: Pull-up on the pin
// Notes: go loads a low pulse length
`timescale 1ns/100ps
`default_nettype none
module rsr_pin_model (
  input wire logic pclk,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic [15:0] low_len,
  input wire logic go,
  output logic pin_level
);
  logic [15:0] cnt = 16'h0000;
  always @(posedge pclk) begin
    if (go) cnt <= low_len;
    else if (cnt != 16'h0000) cnt <= cnt - 16'h0001;
  end
  // Pull-up unless device or agent pulls low
  assign pin_level = !((reset_pin_oe && !reset_pin_out) || cnt != 16'h0000);
endmodule
`default_nettype wire

// ---- verilog/rsr_ctrl.sv ----
// Purpose: Merge reset sources, time reset hold, drive indicator pin, record cause
// Assumes: osc_tick is one pclk pulse per internal oscillator cycle
// Notes: APB slave with zero wait states
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module rsr_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_tick,
  input wire logic supply_above_por,
  input wire logic low_supply_detect,
  input wire logic watchdog_timeout,
  input wire logic stop_mode,
  input wire logic recovery_pin_edge,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  output logic sys_reset,
  output logic cpu_reset,
  output logic ports_to_input,
  output logic regs_load_defaults,
  output logic osc_select_internal,
  output logic [15:0] vector_fetch_addr
);
  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  logic dbg_req;
  logic [7:0] cause;
  rsr_pkg::rsr_config_t cfg;
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire hit_dbg = paddr == rsr_pkg::RSR_OFS_DBG_CTL;
  wire hit_stat = paddr == rsr_pkg::RSR_OFS_STATUS;
  wire hit_cfg = paddr == rsr_pkg::RSR_OFS_CONFIG;
  wire hit_clr = paddr == rsr_pkg::RSR_OFS_CLEAR;
  wire mapped = hit_dbg || hit_stat || hit_cfg || hit_clr;
  wire [31:0] rd_mux = hit_dbg ? {31'h0, dbg_req} :
    hit_stat ? {24'h0, cause} : hit_cfg ? {28'h0, cfg} : 32'h0;
  // ----------------------------------------
  // Pin synchroniser and sources
  // ----------------------------------------
  logic pin_s1;
  logic pin_s2;
  logic pin_low_q;
  rsr_pkg::rsr_state_t state;
  logic [12:0] cnt;
  logic in_stop_rec;
  wire pin_low = !pin_s2 && cfg.pin_reset_en; // [R24]
  wire pin_fall = pin_low && !pin_low_q;
  wire power_src = !supply_above_por || low_supply_detect; // [R04]
  wire wdt_src = watchdog_timeout && cfg.wdt_reset_opt && !stop_mode;
  wire stop_src = stop_mode && (watchdog_timeout || recovery_pin_edge); // [R03]
  wire dbg_src = dbg_req; // [R02]
  wire sys_src = power_src || wdt_src || pin_fall || dbg_src; // [R01]
  wire any_src = sys_src || stop_src;
  wire [12:0] hold_len = cfg.xtal_en ? rsr_pkg::RSR_HOLD_XTAL : rsr_pkg::RSR_HOLD_SHORT; // [R06]
  wire hold_done = osc_tick && (cnt + 13'h0001 >= hold_len);
  wire in_reset = state != rsr_pkg::RSR_RUN;
  wire stop_rec_now = (state == rsr_pkg::RSR_RUN) ? (any_src && !sys_src) : in_stop_rec;
  rsr_pkg::rsr_state_t next_state;
  always_comb begin
    next_state = state;
    case (state)
      rsr_pkg::RSR_RUN: begin
        if (any_src) begin
          next_state = rsr_pkg::RSR_START;
        end
      end
      rsr_pkg::RSR_START: begin
        if (!power_src && cnt == 13'(rsr_pkg::RSR_START_CYC - 1)) begin // [R07] [R08]
          next_state = rsr_pkg::RSR_HOLD;
        end
      end
      rsr_pkg::RSR_HOLD: begin
        if (power_src) begin
          next_state = rsr_pkg::RSR_START; // [R08]
        end else if (hold_done) begin
          next_state = pin_low ? rsr_pkg::RSR_PIN_WAIT : rsr_pkg::RSR_RUN; // [R05] [R09]
        end
      end
      rsr_pkg::RSR_PIN_WAIT: begin
        if (power_src) begin
          next_state = rsr_pkg::RSR_START;
        end else if (!pin_low) begin
          next_state = rsr_pkg::RSR_RUN; // [R09]
        end
      end
      default: begin
        next_state = rsr_pkg::RSR_START;
      end
    endcase
  end
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
      pin_low_q <= 1'b0;
    end else begin
      pin_s1 <= reset_pin_in;
      pin_s2 <= pin_s1; // [R24]
      pin_low_q <= pin_low;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= rsr_pkg::RSR_START;
      cnt <= 13'h0000;
      in_stop_rec <= 1'b0;
    end else begin
      state <= next_state;
      if (next_state != state || (state == rsr_pkg::RSR_HOLD && (sys_src || stop_src))) begin
        cnt <= 13'h0000; // [R24]
      end else if (state == rsr_pkg::RSR_START && power_src) begin
        cnt <= 13'h0000; // [R08]
      end else if (state == rsr_pkg::RSR_START) begin
        cnt <= cnt + 13'h0001;
      end else if (state == rsr_pkg::RSR_HOLD && osc_tick) begin
        cnt <= cnt + 13'h0001; // [R05]
      end
      if (state == rsr_pkg::RSR_RUN && any_src) begin
        in_stop_rec <= !sys_src; // [R19]
      end else if (sys_src) begin
        in_stop_rec <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbg_req <= 1'b0;
      cfg <= rsr_pkg::RSR_CONFIG_RESET;
      cause <= rsr_pkg::RSR_STATUS_RESET;
    end else begin
      if (in_reset && !in_stop_rec) begin
        dbg_req <= 1'b0; // [R21]
      end else if (wr && hit_dbg) begin
        dbg_req <= pwdata[rsr_pkg::RSR_BIT_DBG_RST];
      end
      if (wr && hit_cfg) begin
        cfg <= pwdata[3:0];
      end
      if (wr && hit_clr) begin
        cause <= cause & ~pwdata[7:0];
      end
      if (state == rsr_pkg::RSR_RUN && any_src) begin
        if (power_src || dbg_src) begin
          cause[rsr_pkg::RSR_BIT_POR] <= 1'b1; // [R22]
        end
        if (pin_fall) begin
          cause[rsr_pkg::RSR_BIT_EXT] <= 1'b1; // [R11]
        end
        if (wdt_src || (stop_src && watchdog_timeout)) begin
          cause[rsr_pkg::RSR_BIT_WDT] <= 1'b1;
        end
        if (!sys_src) begin
          cause[rsr_pkg::RSR_BIT_STOP] <= 1'b1;
        end
      end
    end
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      reset_pin_out <= 1'b0;
      reset_pin_oe <= 1'b1;
      sys_reset <= 1'b1;
      cpu_reset <= 1'b1;
      ports_to_input <= 1'b1;
      regs_load_defaults <= 1'b1;
      osc_select_internal <= 1'b1;
      vector_fetch_addr <= rsr_pkg::RSR_VECTOR_ADDR;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
      reset_pin_out <= 1'b0;
      reset_pin_oe <= (next_state inside {rsr_pkg::RSR_START, rsr_pkg::RSR_HOLD}) || cfg.pin_ind_en; // [R12] [R13]
      cpu_reset <= next_state != rsr_pkg::RSR_RUN; // [R15] [R20]
      sys_reset <= (next_state != rsr_pkg::RSR_RUN) && !stop_rec_now; // [R16] [R19]
      ports_to_input <= (next_state != rsr_pkg::RSR_RUN) && !stop_rec_now; // [R14]
      regs_load_defaults <= (state == rsr_pkg::RSR_RUN) && sys_src; // [R16]
      if (next_state != rsr_pkg::RSR_RUN) begin
        osc_select_internal <= 1'b1; // [R18] [R23]
      end else begin
        osc_select_internal <= 1'b0;
      end
      vector_fetch_addr <= rsr_pkg::RSR_VECTOR_ADDR; // [R17]
    end
  end
endmodule
`default_nettype wire
